// ### include/frbsc_regs.vh
// command opcodes, register address, field positions and reset values
`ifndef FRBSC_REGS_VH
`define FRBSC_REGS_VH
`define FRBSC_OP_WREN 8'h06
`define FRBSC_OP_PATCH 8'h0A
`define FRBSC_OP_ASI 8'h25
`define FRBSC_OP_RDSR 8'h65
`define FRBSC_OP_BATT 8'hEF
`define FRBSC_OP_PTAB 8'h5A
`define FRBSC_BSTAT_ADDR 8'h06
`define FRBSC_BSTAT_RES_HI 7
`define FRBSC_BSTAT_RES_LO 6
`define FRBSC_BSTAT_CFG_HI 5
`define FRBSC_BSTAT_CFG_LO 0
`define FRBSC_BSTAT_RES_RESET 2'h0
`define FRBSC_BATT_ABOVE 2'h2
`define FRBSC_BATT_BELOW 2'h3
`define FRBSC_PAGE_BYTES 9'h100
`define FRBSC_PATCH_LAST 9'h101
`define FRBSC_ADDR_BYTES 2'h2
`endif

// ### rtl/frbsc_buf.v
// 256 x 8 page patch buffer with registered read data
module frbsc_buf (
    // clock and enable
    input wire clk_i,
    input wire ce_i,
    // write port
    input wire we_i,
    input wire [7:0] waddr_i,
    input wire [7:0] wdata_i,
    // read port
    input wire [7:0] raddr_i,
    output reg [7:0] rdata_o
);
    reg [7:0] mem [0:255];

    always @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end
endmodule // frbsc_buf

// ### rtl/frbsc_top.v
// serial command sequencer: page patch write, battery test, parameter table read
`include "frbsc_regs.vh"

module frbsc_top (
    // clock, reset, enable
    input wire MCLK_I,
    input wire RESET_N_I,
    input wire CE_I,
    // serial pins
    input wire SCK_I,
    input wire CS_N_I,
    input wire SI_I,
    output reg SO_O,
    output reg SO_OE_N_O,
    // status logic
    input wire WRITE_ENABLE_LATCH_I,
    input wire [5:0] BATT_CFG_I,
    output reg LATCH_CLEAR_O,
    output reg READY_BUSY_O,
    // battery detector
    input wire BATT_DONE_I,
    input wire BATT_LOW_I,
    output reg BATT_START_O,
    output reg [5:0] BATT_PARAM_O,
    // parameter table
    output reg [7:0] PTAB_ADDR_O,
    input wire [7:0] PTAB_DATA_I,
    // array write port
    output reg ARRAY_WR_O,
    output reg [21:0] ARRAY_ADDR_O,
    output reg [7:0] ARRAY_DATA_O
);
    localparam ST_CMD = 4'h0;
    localparam ST_ADDR = 4'h1;
    localparam ST_DATA = 4'h2;
    localparam ST_DUMMY = 4'h3;
    localparam ST_PTAB = 4'h4;
    localparam ST_SRADR = 4'h5;
    localparam ST_SROUT = 4'h6;
    localparam ST_ASI = 4'h7;
    localparam ST_BATT = 4'h8;
    localparam ST_SKIP = 4'h9;

    reg rst_s1_q, rst_s2_q;
    wire rst_n = rst_s2_q;
    reg sck_s1_q, sck_s2_q, sck_s3_q;
    reg cs_s1_q, cs_s2_q, cs_s3_q;
    reg si_s1_q, si_s2_q;
    reg [3:0] state_q;
    reg [7:0] cmd_q;
    reg [2:0] bitcnt_q;
    reg [6:0] sr_in_q;
    reg [1:0] acnt_q;
    reg [15:0] addr_q;
    reg [13:0] page_q;
    reg [7:0] ptr_q;
    reg [255:0] valid_q;
    reg got_data_q;
    reg mode3_q;
    reg [7:0] sr_sel_q;
    reg [2:0] obit_q;
    reg [7:0] out_sr_q;
    reg busy_q;
    reg patch_q;
    reg batt_q;
    reg [8:0] pidx_q;
    reg s1_v_q;
    reg [7:0] s1_idx_q;
    reg [1:0] batt_res_q;
    reg buf_we;
    wire [7:0] buf_rdata;

    wire sck_rise = sck_s2_q & ~sck_s3_q;
    wire sck_fall = ~sck_s2_q & sck_s3_q;
    wire cs_fall = ~cs_s2_q & cs_s3_q;
    wire cs_rise = cs_s2_q & ~cs_s3_q;
    wire in_frame = ~cs_s2_q;
    wire byte_done = in_frame & sck_rise & (bitcnt_q == 3'h7);
    wire [7:0] nb = {sr_in_q, si_s2_q};
    wire [7:0] batt_stat = {batt_res_q, BATT_CFG_I};
    wire [7:0] status_byte = (sr_sel_q == `FRBSC_BSTAT_ADDR) ? batt_stat : 8'h00;
    wire [7:0] out_byte = (state_q == ST_PTAB) ? PTAB_DATA_I : status_byte;
    // reset release through two flops; assertion stays asynchronous
    always @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else if (CE_I) begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // pins cross in through two flops, third flop only for edges
    always @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            si_s1_q <= 1'b0;
            si_s2_q <= 1'b0;
        end else if (CE_I) begin
            sck_s1_q <= SCK_I;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            cs_s1_q <= CS_N_I;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            si_s1_q <= SI_I;
            si_s2_q <= si_s1_q;
        end
    end

    // buffer write happens on each completed data byte
    always @* begin
        buf_we = byte_done & (state_q == ST_DATA);
    end

    frbsc_buf u_buf (
        .clk_i(MCLK_I),
        .ce_i(CE_I),
        .we_i(buf_we),
        .waddr_i(ptr_q),
        .wdata_i(nb),
        .raddr_i(pidx_q[7:0]),
        .rdata_o(buf_rdata)
    );

    // frame decoder and serial output
    always @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SKIP;
            cmd_q <= 8'h00;
            bitcnt_q <= 3'h0;
            sr_in_q <= 7'h00;
            acnt_q <= 2'h0;
            addr_q <= 16'h0000;
            page_q <= 14'h0000;
            ptr_q <= 8'h00;
            valid_q <= {256{1'b0}};
            got_data_q <= 1'b0;
            mode3_q <= 1'b0;
            sr_sel_q <= 8'h00;
            obit_q <= 3'h0;
            out_sr_q <= 8'h00;
            PTAB_ADDR_O <= 8'h00;
            SO_O <= 1'b0;
            SO_OE_N_O <= 1'b1;
        end else if (CE_I) begin
            if (cs_fall) begin
                state_q <= ST_CMD;
                bitcnt_q <= 3'h0;
                obit_q <= 3'h0;
                // clock level at select picks mode 0 or mode 3
                mode3_q <= sck_s2_q;
            end else if (cs_rise) begin
                state_q <= ST_SKIP;
                SO_OE_N_O <= 1'b1;
            end else if (in_frame) begin
                if (sck_rise) begin
                    bitcnt_q <= bitcnt_q + 3'h1;
                    sr_in_q <= nb[6:0];
                end
                if (byte_done) begin
                    case (state_q)
                        ST_CMD: begin
                            cmd_q <= nb;
                            acnt_q <= 2'h0;
                            case (nb)
                                `FRBSC_OP_PATCH: begin
                                    state_q <= ST_ADDR;
                                    valid_q <= {256{1'b0}};
                                    got_data_q <= 1'b0;
                                end
                                `FRBSC_OP_PTAB: state_q <= ST_ADDR;
                                `FRBSC_OP_RDSR: state_q <= ST_SRADR;
                                `FRBSC_OP_ASI: state_q <= mode3_q ? ST_DUMMY : ST_ASI;
                                `FRBSC_OP_BATT: state_q <= ST_BATT;
                                default: state_q <= ST_SKIP;
                            endcase
                        end
                        ST_ADDR: begin
                            addr_q <= {addr_q[7:0], nb};
                            acnt_q <= acnt_q + 2'h1;
                            if (acnt_q == `FRBSC_ADDR_BYTES) begin
                                if (cmd_q == `FRBSC_OP_PATCH) begin
                                    // top two address bits dropped
                                    page_q <= addr_q[13:0];
                                    ptr_q <= nb;
                                    state_q <= ST_DATA;
                                end else begin
                                    // high bytes ignored: table is 256 bytes
                                    PTAB_ADDR_O <= nb;
                                    state_q <= ST_DUMMY;
                                end
                            end
                        end
                        ST_DATA: begin
                            valid_q[ptr_q] <= 1'b1;
                            ptr_q <= ptr_q + 8'h01;
                            got_data_q <= 1'b1;
                        end
                        ST_DUMMY: begin
                            state_q <= (cmd_q == `FRBSC_OP_ASI) ? ST_ASI : ST_PTAB;
                        end
                        ST_SRADR: begin
                            sr_sel_q <= nb;
                            state_q <= ST_SROUT;
                        end
                        ST_BATT: state_q <= ST_SKIP;
                        default: state_q <= state_q;
                    endcase
                end
                // data out changes on falling clock, msb first
                if (sck_fall && (state_q == ST_PTAB || state_q == ST_SROUT)) begin
                    SO_OE_N_O <= 1'b0;
                    obit_q <= obit_q + 3'h1;
                    if (obit_q == 3'h0) begin
                        SO_O <= out_byte[7];
                        out_sr_q <= {out_byte[6:0], 1'b0};
                        if (state_q == ST_PTAB) begin
                            // eight-bit pointer wraps with no gap
                            PTAB_ADDR_O <= PTAB_ADDR_O + 8'h01;
                        end
                    end else begin
                        SO_O <= out_sr_q[7];
                        out_sr_q <= {out_sr_q[6:0], 1'b0};
                    end
                end
                // flag follows every cycle, no clock needed
                if (state_q == ST_ASI) begin
                    SO_OE_N_O <= 1'b0;
                    SO_O <= busy_q;
                end
            end
        end
    end

    // patch walker, battery test and busy flag
    always @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            patch_q <= 1'b0;
            batt_q <= 1'b0;
            pidx_q <= 9'h000;
            s1_v_q <= 1'b0;
            s1_idx_q <= 8'h00;
            batt_res_q <= `FRBSC_BSTAT_RES_RESET;
            LATCH_CLEAR_O <= 1'b0;
            READY_BUSY_O <= 1'b0;
            BATT_START_O <= 1'b0;
            BATT_PARAM_O <= 6'h00;
            ARRAY_WR_O <= 1'b0;
            ARRAY_ADDR_O <= 22'h000000;
            ARRAY_DATA_O <= 8'h00;
        end else if (CE_I) begin
            LATCH_CLEAR_O <= 1'b0;
            BATT_START_O <= 1'b0;
            // a new operation is refused while one still runs
            if (cs_rise && !busy_q) begin
                if (cmd_q == `FRBSC_OP_PATCH && state_q == ST_DATA && got_data_q
                        && bitcnt_q == 3'h0 && WRITE_ENABLE_LATCH_I) begin
                    busy_q <= 1'b1;
                    patch_q <= 1'b1;
                    pidx_q <= 9'h000;
                    LATCH_CLEAR_O <= 1'b1;
                end
                if (state_q == ST_BATT && bitcnt_q == 3'h0) begin
                    busy_q <= 1'b1;
                    batt_q <= 1'b1;
                    BATT_START_O <= 1'b1;
                    BATT_PARAM_O <= BATT_CFG_I;
                end
            end
            // walk every location, write only the marked ones
            s1_v_q <= patch_q && (pidx_q < `FRBSC_PAGE_BYTES) && valid_q[pidx_q[7:0]];
            s1_idx_q <= pidx_q[7:0];
            ARRAY_WR_O <= s1_v_q;
            ARRAY_ADDR_O <= {page_q, s1_idx_q};
            ARRAY_DATA_O <= buf_rdata;
            if (patch_q) begin
                pidx_q <= pidx_q + 9'h001;
                if (pidx_q == `FRBSC_PATCH_LAST) begin
                    patch_q <= 1'b0;
                    busy_q <= 1'b0;
                end
            end
            if (batt_q && BATT_DONE_I) begin
                batt_q <= 1'b0;
                busy_q <= 1'b0;
                batt_res_q <= BATT_LOW_I ? `FRBSC_BATT_BELOW : `FRBSC_BATT_ABOVE;
            end
            READY_BUSY_O <= busy_q;
        end
    end
endmodule // frbsc_top

// ### verif/frbsc_properties.sv
// port assertions for the serial command sequencer
module frbsc_chk (
    // clock, reset
    input wire MCLK_I,
    input wire RESET_N_I,
    // serial
    input wire CS_N_I,
    input wire SO_OE_N_O,
    // status, battery
    input wire WRITE_ENABLE_LATCH_I,
    input wire LATCH_CLEAR_O,
    input wire READY_BUSY_O,
    input wire BATT_DONE_I,
    input wire BATT_START_O,
    input wire [5:0] BATT_CFG_I,
    input wire [5:0] BATT_PARAM_O,
    // array
    input wire ARRAY_WR_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    // six cycles cover the pin synchroniser
    property p_oe_idle;
        CS_N_I [*6] |-> SO_OE_N_O;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("so driven outside frame");
    property p_oe_frame;
        !SO_OE_N_O |-> !$past(CS_N_I, 6);
    endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("so driven without select");
    property p_latch_gate;
        LATCH_CLEAR_O |-> $past(WRITE_ENABLE_LATCH_I);
    endproperty
    a_latch_gate: assert property (p_latch_gate) else $error("patch taken with latch clear");
    property p_patch_busy;
        LATCH_CLEAR_O |=> READY_BUSY_O ##[250:270] !READY_BUSY_O;
    endproperty
    a_patch_busy: assert property (p_patch_busy) else $error("patch busy span wrong");
    property p_wr_busy;
        ARRAY_WR_O |=> READY_BUSY_O;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("array write while ready");
    property p_batt_busy;
        BATT_START_O |=> READY_BUSY_O;
    endproperty
    a_batt_busy: assert property (p_batt_busy) else $error("test runs while ready");
    property p_batt_param;
        BATT_START_O |=> BATT_PARAM_O == $past(BATT_CFG_I, 2);
    endproperty
    a_batt_param: assert property (p_batt_param) else $error("test parameters wrong");
    property p_batt_done;
        BATT_DONE_I && READY_BUSY_O |-> ##[1:3] !READY_BUSY_O;
    endproperty
    a_batt_done: assert property (p_batt_done) else $error("busy kept after done");
endmodule // frbsc_chk
bind frbsc_top frbsc_chk frbsc_chk_inst (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I),
    .CS_N_I(CS_N_I), .SO_OE_N_O(SO_OE_N_O), .WRITE_ENABLE_LATCH_I(WRITE_ENABLE_LATCH_I),
    .LATCH_CLEAR_O(LATCH_CLEAR_O),
    .READY_BUSY_O(READY_BUSY_O), .BATT_DONE_I(BATT_DONE_I), .BATT_START_O(BATT_START_O),
    .BATT_CFG_I(BATT_CFG_I), .BATT_PARAM_O(BATT_PARAM_O), .ARRAY_WR_O(ARRAY_WR_O));

// ### verif/frbsc_host.sv
// host serial controller model, modes 0 and 3, msb-first bytes
module frbsc_host (
    // serial pins out
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    // device answer
    input wire logic so_i,
    input wire logic so_oe_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_NS = 80;
    logic idle_hi;
    // sck stands still at its idle level between frames
    initial begin
        idle_hi = 1'b0;
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b1;
    end
    // idle level picks the mode; call only with select high
    task automatic set_mode(input logic m3);
        idle_hi = m3;
        sck_o = m3;
        #(HALF_NS);
    endtask
    task automatic begin_frame();
        cs_n_o = 1'b0;
        #(HALF_NS);
    endtask
    // released line reads unknown so it never passes a compare
    // clock falls at each bit start, stays high after the last rise
    task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck_o = 1'b0;
            si_o = b[i];
            #(HALF_NS) sck_o = 1'b1;
            r[i] = so_oe_n_i ? 1'bx : so_i;
            #(HALF_NS);
        end
    endtask
    task automatic end_frame();
        sck_o = idle_hi;
        #(HALF_NS) cs_n_o = 1'b1;
        si_o = ~si_o;
        #(3 * HALF_NS);
    endtask
endmodule // frbsc_host

// ### verif/testbench.sv
// testbench for the serial command sequencer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, wr_latch, batt_done, batt_low;
    logic [5:0] batt_cfg;
    logic [7:0] ptab_data, r, a;
    wire sck, cs_n, si, so, so_oe_n, latch_clear, rdy_busy, batt_start, array_wr;
    wire [5:0] batt_param;
    wire [7:0] ptab_addr, array_data;
    wire [21:0] array_addr;
    int err_count, checked, wclr, bstart;
    logic [29:0] wr_q[$];
    frbsc_host frbsc_host_inst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so),
        .so_oe_n_i(so_oe_n));
    frbsc_top frbsc_top_inst (.MCLK_I(mclk), .RESET_N_I(reset_n), .CE_I(1'b1), .SCK_I(sck),
        .CS_N_I(cs_n), .SI_I(si), .SO_O(so), .SO_OE_N_O(so_oe_n),
        .WRITE_ENABLE_LATCH_I(wr_latch),
        .BATT_CFG_I(batt_cfg), .LATCH_CLEAR_O(latch_clear), .READY_BUSY_O(rdy_busy),
        .BATT_DONE_I(batt_done), .BATT_LOW_I(batt_low), .BATT_START_O(batt_start),
        .BATT_PARAM_O(batt_param), .PTAB_ADDR_O(ptab_addr), .PTAB_DATA_I(ptab_data),
        .ARRAY_WR_O(array_wr), .ARRAY_ADDR_O(array_addr), .ARRAY_DATA_O(array_data));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // device side: table contents, array write log, pulse counts
    always @(negedge mclk) begin
        ptab_data <= ptab_addr ^ 8'hA5;
        if (array_wr === 1'b1) wr_q.push_back({array_addr, array_data});
        if (latch_clear === 1'b1) wclr++;
        if (batt_start === 1'b1) bstart++;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (rdy_busy !== 1'b0 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        check("busy end", n < 2000, 1);
    endtask
    task automatic patch(input logic [23:0] ad, input int nb, input int extra);
        frbsc_host_inst.begin_frame();
        frbsc_host_inst.xfer(8'h0A, 8, r);
        for (int i = 2; i >= 0; i--) frbsc_host_inst.xfer(ad[8*i +: 8], 8, r);
        for (int i = 0; i < nb; i++) frbsc_host_inst.xfer(8'hC0 + i[7:0], 8, r);
        if (extra > 0) frbsc_host_inst.xfer(8'hFF, extra, r);
        frbsc_host_inst.end_frame();
        wait_idle();
    endtask
    initial begin
        reset_n = 1'b0;
        wr_latch = 1'b0;
        batt_done = 1'b0;
        batt_low = 1'b0;
        batt_cfg = 6'h2B;
        ptab_data = 8'h00;
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        repeat (8) @(negedge mclk);
        wr_latch = 1'b1;
        patch(24'hC123FE, 3, 0);
        check("writes", wr_q.size(), 3);
        check("wr0", wr_q[0], {22'h012300, 8'hC2});
        check("wr1", wr_q[1], {22'h0123FE, 8'hC0});
        check("wr2", wr_q[2], {22'h0123FF, 8'hC1});
        patch(24'h000010, 1, 3);
        @(negedge mclk) wr_latch = 1'b0;
        patch(24'h000010, 2, 0);
        check("writes", wr_q.size(), 3);
        check("latch clears", wclr, 1);
        for (int k = 0; k < 2; k++) begin
            @(negedge mclk) batt_low = k[0];
            batt_cfg = k[0] ? 6'h15 : 6'h2B;
            frbsc_host_inst.begin_frame();
            frbsc_host_inst.xfer(8'hEF, 8, r);
            frbsc_host_inst.end_frame();
            check("param", batt_param, batt_cfg);
            // second pass watches the test in mode 3
            frbsc_host_inst.set_mode(k[0]);
            frbsc_host_inst.begin_frame();
            frbsc_host_inst.xfer(8'h25, 8, r);
            if (k[0]) begin
                check("asi dummy", so_oe_n, 1);
                frbsc_host_inst.xfer(8'h00, 8, r);
            end
            repeat (20) @(negedge mclk);
            check("so busy", so, 1);
            batt_done = 1'b1;
            @(negedge mclk) batt_done = 1'b0;
            repeat (10) @(negedge mclk);
            check("so ready", so, 0);
            frbsc_host_inst.end_frame();
            frbsc_host_inst.set_mode(1'b0);
            frbsc_host_inst.begin_frame();
            frbsc_host_inst.xfer(8'h65, 8, r);
            frbsc_host_inst.xfer(8'h06, 8, r);
            frbsc_host_inst.xfer(8'h00, 8, r);
            frbsc_host_inst.end_frame();
            check("status", r, {1'b1, k[0], batt_cfg});
        end
        check("tests", bstart, 2);
        frbsc_host_inst.begin_frame();
        frbsc_host_inst.xfer(8'h5A, 8, r);
        frbsc_host_inst.xfer(8'h00, 8, r);
        frbsc_host_inst.xfer(8'h00, 8, r);
        frbsc_host_inst.xfer(8'hFE, 8, r);
        frbsc_host_inst.xfer(8'h00, 8, r);
        a = 8'hFE;
        repeat (3) begin
            frbsc_host_inst.xfer(8'h00, 8, r);
            check("table", r, a ^ 8'hA5);
            a = a + 8'h01;
        end
        frbsc_host_inst.xfer(8'h00, 3, r);
        frbsc_host_inst.end_frame();
        check("so released", so_oe_n, 1);
        final_report();
    end
    // tests take about 60 us; limit leaves ample margin
    initial begin
        #200000;
        err_count++;
        final_report();
    end
endmodule // testbench
